// ===== hw/fips_pkg.sv
// constants and types of the flash iap program sequencer
// Behaviour
// [R1] mode 001 plus program start erases the page in the address registers.
// [R2] mode 000 plus program start programs the write buffer into flash.
// [R3] program start reads high during erase or write, self-clears at the end.
// [R4] software writes data low byte first; high byte write commits the word.
// [R5] non-adjacent words need new address and separate write cycle each.
// [R6] erase always clears a whole page, never single words.
// [R7] write transfers the whole 32-word buffer inside the selected page.
// [R8] software must unlock erase/write before requesting erase or write.
// [R9] clear write buffer bit empties the buffer for a retry.
// [R10] a new write to the same page is accepted without erase.
// [R11] software blank-checks the page after each erase, repeating on failure.
// [R12] software verifies written words, clears buffer and reloads on mismatch.
// [R13] cpu is stalled while an erase or write runs.
// [R14] program time select chooses how long program start stays high.
// [R15] software clears the enabled flag when erase/write work is done.
// [R16] read needs mode 011, read enable, address, then read start.
// [R17] read completion loads data registers and clears read start.
// [R18] read start drops three instruction cycles after set; cpu stalled meanwhile.
// [R19] reads work without the unlock procedure.
// [R20] software should run the fastest system clock during write and verify.
// [R21] erase tagging by high-byte writes increments offset, stopping at 11111b.
// [R22] buffer holds 32 words; offset increments per high byte, saturating.
// [R23] mode 110 plus unlock start runs a timer; matching key sets enabled flag.
// [R24] unlock timer expiry clears unlock start regardless of the pattern.
// [R25] erase or write start is ignored while the enabled flag is low.
// [R26] target address is latched when an operation starts.
package fips_pkg;
	// ----------------------------------------
	// register map (index = byte address)
	// ----------------------------------------
	localparam logic [4:0] REG_CTRL0 = 5'h00;
	localparam logic [4:0] REG_CTRL1 = 5'h01;
	localparam logic [4:0] REG_CTRL2 = 5'h02;
	localparam logic [4:0] REG_ADDR_LO = 5'h03;
	localparam logic [4:0] REG_ADDR_HI = 5'h04;
	localparam logic [4:0] REG_DATA_LO = 5'h05;
	localparam logic [4:0] REG_DATA_HI = 5'h06;
	localparam logic [4:0] REG_PAT_BASE = 5'h07;
	localparam int PAT_NUM = 6;
	// ----------------------------------------
	// fields
	// ----------------------------------------
	localparam int C0_UNLOCK = 3;
	localparam int C0_ENABLED = 4;
	localparam int C0_RDEN = 5;
	localparam int C1_PSTART = 0;
	localparam int C1_RSTART = 1;
	localparam int C1_CLEAR_WRITE_BUFFER_BIT = 2;
	localparam int C2_PTSEL = 0;
	localparam logic [2:0] MODE_WRITE = 3'h0;
	localparam logic [2:0] MODE_ERASE = 3'h1;
	localparam logic [2:0] MODE_READ = 3'h3;
	localparam logic [2:0] MODE_UNLOCK = 3'h6;
	localparam logic [2:0] MODE_RST = 3'h0;
	// pattern registers low 1..3 then high 1..3, first in low bits
	localparam logic [47:0] UNLOCK_KEY = 48'h40_09_04_c3_0d_00;
	// ----------------------------------------
	// page geometry
	// ----------------------------------------
	localparam int ADDR_W = 13;
	localparam int OFF_W = 5;
	localparam logic [OFF_W-1:0] OFF_LAST = 5'h1f;
	localparam logic [5:0] PAGE_WORDS = 6'h20;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int PROG_TIME_SHORT_US = 2000;
	localparam int PROG_TIME_LONG_US = 4000;
	localparam int UNLOCK_TIME_US = 1000;
	localparam int READ_INSTR = 3;
	localparam int CLK_PER_INSTR = 4;
	localparam int READ_CYC = READ_INSTR * CLK_PER_INSTR;
	localparam int TMR_W = 20;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic we;
		logic re;
		logic [4:0] addr;
		logic [7:0] wdata;
	} fips_bus_t;
	typedef struct packed {
		logic we;
		logic erase;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [15:0] wdata;
	} fips_flash_t;
endpackage

// ===== hw/fips_wbuf.sv
// page write buffer memory with registered read
`timescale 1ns/1ns
module fips_wbuf (
	// clock
	input wire logic clk_i,
	// write port
	input wire logic we_i,
	input wire logic [4:0] waddr_i,
	input wire logic [15:0] wdata_i,
	// read port
	input wire logic [4:0] raddr_i,
	output logic [15:0] rdata_o
);
	logic [15:0] mem_q [32];

	always_ff @(posedge clk_i)
	begin
		if (we_i)
			mem_q[waddr_i] <= wdata_i;
	end

	always_ff @(posedge clk_i)
	begin
		rdata_o <= mem_q[raddr_i];
	end
endmodule // fips_wbuf

// ===== hw/fips_top.sv
// flash iap program sequencer: registers, unlock, erase, write, read
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module fips_top #(
	parameter int PROG_CYC_SHORT = fips_pkg::PROG_TIME_SHORT_US * fips_pkg::CLK_MHZ,
	parameter int PROG_CYC_LONG = fips_pkg::PROG_TIME_LONG_US * fips_pkg::CLK_MHZ,
	parameter int UNLOCK_CYC = fips_pkg::UNLOCK_TIME_US * fips_pkg::CLK_MHZ
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// register bus
	input wire fips_pkg::fips_bus_t bus_i,
	output logic [7:0] rdata_o,
	// flash array
	output fips_pkg::fips_flash_t flash_o,
	input wire logic [15:0] flash_rdata_i,
	// cpu
	output logic cpu_stall_o
);
	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_PROG = 4'h2,
		S_WAIT = 4'h4,
		S_READ = 4'h8
	} fips_state_t;

	fips_state_t st_q;
	logic [2:0] mode_q;
	logic unlock_q;
	logic enabled_q;
	logic rden_q;
	logic ptsel_q;
	logic [7:0] addr_lo_q;
	logic [4:0] addr_hi_q;
	logic [7:0] data_lo_q;
	logic [7:0] data_hi_q;
	logic [47:0] pat_q;
	logic [fips_pkg::OFF_W-1:0] off_q;
	logic [31:0] valid_q;
	logic [fips_pkg::ADDR_W-1:0] lat_q;
	logic [5:0] idx_q;
	logic [fips_pkg::TMR_W-1:0] tmr_q;
	logic [fips_pkg::TMR_W-1:0] ulk_q;
	logic [15:0] buf_rd;
	logic [5:0] idx_m1;
	logic wr_c0, wr_c1, wr_dhi, idle, go_erase, go_prog, go_read, clear_write_buffer_bit, load_en;
	logic [fips_pkg::TMR_W-1:0] prog_cyc;

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	assign wr_c0 = bus_i.we && bus_i.addr == fips_pkg::REG_CTRL0;
	assign wr_c1 = bus_i.we && bus_i.addr == fips_pkg::REG_CTRL1;
	assign wr_dhi = bus_i.we && bus_i.addr == fips_pkg::REG_DATA_HI;
	assign idle = st_q == S_IDLE;
	assign clear_write_buffer_bit = wr_c1 && bus_i.wdata[fips_pkg::C1_CLEAR_WRITE_BUFFER_BIT];
	assign load_en = enabled_q && (mode_q == fips_pkg::MODE_WRITE
		|| mode_q == fips_pkg::MODE_ERASE);
	// locked starts do nothing (see [R25]); reads need no unlock (see [R19])
	assign go_erase = wr_c1 && bus_i.wdata[fips_pkg::C1_PSTART] && idle && enabled_q
		&& mode_q == fips_pkg::MODE_ERASE; // see [R1]
	assign go_prog = wr_c1 && bus_i.wdata[fips_pkg::C1_PSTART] && idle && enabled_q
		&& mode_q == fips_pkg::MODE_WRITE; // see [R2] see [R10]
	assign go_read = wr_c1 && bus_i.wdata[fips_pkg::C1_RSTART] && idle && rden_q
		&& mode_q == fips_pkg::MODE_READ; // see [R16]
	assign idx_m1 = idx_q - 6'h01;
	assign prog_cyc = ptsel_q ? fips_pkg::TMR_W'(PROG_CYC_LONG)
		: fips_pkg::TMR_W'(PROG_CYC_SHORT);

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mode_q <= fips_pkg::MODE_RST;
			rden_q <= 1'b0;
			ptsel_q <= 1'b0;
		end
		else
		begin
			if (wr_c0)
			begin
				mode_q <= bus_i.wdata[2:0];
				rden_q <= bus_i.wdata[fips_pkg::C0_RDEN];
			end
			if (bus_i.we && bus_i.addr == fips_pkg::REG_CTRL2)
				ptsel_q <= bus_i.wdata[fips_pkg::C2_PTSEL];
		end
	end

	// ----------------------------------------
	// unlock procedure
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			unlock_q <= 1'b0;
			ulk_q <= '0;
		end
		else if (wr_c0 && bus_i.wdata[fips_pkg::C0_UNLOCK]
			&& bus_i.wdata[2:0] == fips_pkg::MODE_UNLOCK)
		begin
			unlock_q <= 1'b1; // see [R23]
			ulk_q <= fips_pkg::TMR_W'(UNLOCK_CYC);
		end
		else if (unlock_q)
		begin
			ulk_q <= ulk_q - 1'b1;
			if (ulk_q == fips_pkg::TMR_W'(1))
				unlock_q <= 1'b0; // see [R24]
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pat_q <= '0;
		else if (wr_c0 && bus_i.wdata[fips_pkg::C0_UNLOCK])
			pat_q <= '0;
		else
			for (int k = 0; k < fips_pkg::PAT_NUM; k++)
				if (bus_i.we && bus_i.addr == fips_pkg::REG_PAT_BASE + 5'(k))
					pat_q[k*8 +: 8] <= bus_i.wdata;
	end

	// key match sets the flag and wins over a software clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			enabled_q <= 1'b0;
		else if (unlock_q && mode_q == fips_pkg::MODE_UNLOCK
			&& pat_q == fips_pkg::UNLOCK_KEY)
			enabled_q <= 1'b1; // see [R23]
		else if (wr_c0 && !bus_i.wdata[fips_pkg::C0_ENABLED])
			enabled_q <= 1'b0;
	end

	// ----------------------------------------
	// address, data and write buffer loading
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			addr_lo_q <= 8'h00;
			addr_hi_q <= 5'h00;
			off_q <= '0;
		end
		else
		begin
			if (bus_i.we && bus_i.addr == fips_pkg::REG_ADDR_LO)
			begin
				addr_lo_q <= bus_i.wdata;
				off_q <= bus_i.wdata[fips_pkg::OFF_W-1:0];
			end
			else if (wr_dhi && load_en && off_q != fips_pkg::OFF_LAST)
				off_q <= off_q + 1'b1; // see [R21] see [R22]
			if (bus_i.we && bus_i.addr == fips_pkg::REG_ADDR_HI)
				addr_hi_q <= bus_i.wdata[4:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			data_lo_q <= 8'h00;
			data_hi_q <= 8'h00;
		end
		else if (st_q == S_READ && tmr_q == fips_pkg::TMR_W'(1))
		begin
			data_lo_q <= flash_rdata_i[7:0]; // see [R17]
			data_hi_q <= flash_rdata_i[15:8];
		end
		else
		begin
			if (bus_i.we && bus_i.addr == fips_pkg::REG_DATA_LO)
				data_lo_q <= bus_i.wdata;
			if (wr_dhi)
				data_hi_q <= bus_i.wdata;
		end
	end

	// unloaded words go out as the erased value
	always_ff @(posedge clk_i)
	begin
		if (rst_i || clear_write_buffer_bit)
			valid_q <= '0; // see [R9]
		else if (wr_dhi && load_en && mode_q == fips_pkg::MODE_WRITE)
			valid_q[off_q] <= 1'b1;
	end

	fips_wbuf u_wbuf (
		.clk_i(clk_i),
		.we_i(wr_dhi && load_en && mode_q == fips_pkg::MODE_WRITE),
		.waddr_i(off_q),
		.wdata_i({bus_i.wdata, data_lo_q}),
		.raddr_i(idx_q[4:0]),
		.rdata_o(buf_rd)
	);

	// ----------------------------------------
	// operation sequencer
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st_q <= S_IDLE;
		else
			unique case (st_q)
				S_IDLE:
					if (go_erase)
						st_q <= S_WAIT;
					else if (go_prog)
						st_q <= S_PROG;
					else if (go_read)
						st_q <= S_READ;
				S_PROG:
					if (idx_q == fips_pkg::PAGE_WORDS)
						st_q <= S_WAIT;
				S_WAIT, S_READ:
					if (tmr_q == fips_pkg::TMR_W'(1))
						st_q <= S_IDLE; // see [R3] see [R17]
				default:
					st_q <= S_IDLE;
			endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tmr_q <= '0;
		else if (go_erase || (st_q == S_PROG && idx_q == fips_pkg::PAGE_WORDS))
			tmr_q <= prog_cyc; // see [R14]
		else if (go_read)
			tmr_q <= fips_pkg::TMR_W'(fips_pkg::READ_CYC); // see [R18]
		else if (tmr_q != '0)
			tmr_q <= tmr_q - 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			lat_q <= '0;
			idx_q <= '0;
		end
		else
		begin
			if (go_erase || go_prog || go_read)
				lat_q <= {addr_hi_q, addr_lo_q}; // see [R26]
			if (st_q == S_PROG)
				idx_q <= idx_q + 6'h01;
			else
				idx_q <= '0;
		end
	end

	// ----------------------------------------
	// flash array commands
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			flash_o <= '0;
		else
		begin
			flash_o.we <= 1'b0;
			flash_o.erase <= 1'b0;
			flash_o.rd <= 1'b0;
			if (go_erase)
			begin
				flash_o.erase <= 1'b1;
				flash_o.addr <= {addr_hi_q, addr_lo_q[7:5], 5'h00}; // see [R6]
			end
			else if (go_read)
			begin
				flash_o.rd <= 1'b1;
				flash_o.addr <= {addr_hi_q, addr_lo_q};
			end
			else if (st_q == S_PROG && idx_q != 6'h00)
			begin
				flash_o.we <= 1'b1; // see [R7]
				flash_o.addr <= {lat_q[12:5], idx_m1[4:0]};
				flash_o.wdata <= valid_q[idx_m1[4:0]] ? buf_rd : 16'h0000;
			end
		end
	end

	assign cpu_stall_o = !idle; // see [R13] see [R18]

	// ----------------------------------------
	// register read back
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !bus_i.re)
			rdata_o <= 8'h00;
		else
			unique case (bus_i.addr)
				fips_pkg::REG_CTRL0:
					rdata_o <= {2'h0, rden_q, enabled_q, unlock_q, mode_q};
				fips_pkg::REG_CTRL1:
					rdata_o <= {6'h00, st_q == S_READ, st_q == S_PROG || st_q == S_WAIT};
				fips_pkg::REG_CTRL2:
					rdata_o <= {7'h00, ptsel_q};
				fips_pkg::REG_ADDR_LO:
					rdata_o <= addr_lo_q;
				fips_pkg::REG_ADDR_HI:
					rdata_o <= {3'h0, addr_hi_q};
				fips_pkg::REG_DATA_LO:
					rdata_o <= data_lo_q;
				fips_pkg::REG_DATA_HI:
					rdata_o <= data_hi_q;
				default:
					rdata_o <= 8'h00;
			endcase
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [5:0] wcnt_q;
	always_ff @(posedge clk_i)
	begin
		if (rst_i || idle)
			wcnt_q <= '0;
		else if (flash_o.we)
			wcnt_q <= wcnt_q + 6'h01;
	end

	erase_whole_page_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R6]
		flash_o.erase |-> flash_o.addr[4:0] == 5'h00 && st_q == S_WAIT)
		else $error("erase not page aligned");
	prog_in_page_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R7]
		flash_o.we |-> flash_o.addr[12:5] == lat_q[12:5])
		else $error("write left the page");
	prog_full_page_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R7]
		st_q == S_WAIT && $past(st_q) == S_PROG |=> wcnt_q == fips_pkg::PAGE_WORDS)
		else $error("buffer not written whole");
	stall_busy_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R13]
		$past(go_erase || go_prog) |-> cpu_stall_o)
		else $error("cpu not stalled");
	read_time_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R18]
		$rose(st_q == S_READ) |-> ##11 st_q == S_READ ##1 idle)
		else $error("read length wrong");
	locked_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R25]
		wr_c1 && bus_i.wdata[fips_pkg::C1_PSTART] && !enabled_q && idle && !go_read |=> idle)
		else $error("locked start accepted");
	read_unlocked_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R19]
		go_read |=> st_q == S_READ && flash_o.rd)
		else $error("read refused");
	unlock_timeout_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R24]
		unlock_q && ulk_q == fips_pkg::TMR_W'(1) && !wr_c0 |=> !unlock_q)
		else $error("unlock not timed out");
	clear_buffer_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R9]
		clear_write_buffer_bit |=> valid_q == 32'h0000_0000)
		else $error("buffer not cleared");
	offset_sat_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R22]
		wr_dhi && off_q == fips_pkg::OFF_LAST |=> off_q == fips_pkg::OFF_LAST)
		else $error("offset wrapped");
	read_capture_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [R17]
		st_q == S_READ && tmr_q == fips_pkg::TMR_W'(1) |=> idle
		&& {data_hi_q, data_lo_q} == $past(flash_rdata_i))
		else $error("read data not captured");
endmodule // fips_top

// ===== tb/fips_flash_model.sv
// behavioural flash array answering the sequencer
`timescale 1ns/1ns
module fips_flash_model (
	// clock
	input wire logic clk_i,
	// array side
	input wire fips_pkg::fips_flash_t flash_i,
	output logic [15:0] rdata_o
);
	logic [15:0] mem [0:8191];
	logic [15:0] val_q = 16'h5a5a;
	logic [4:0] hold_q = 5'h00;
	// ----------------------------------------
	// array updates
	// ----------------------------------------
	always @(posedge clk_i)
	begin
		if (flash_i.erase)
		begin
			for (int i = 0; i < 32; i++)
				mem[{flash_i.addr[12:5], 5'(i)}] <= 16'h0000;
		end
		if (flash_i.we)
			mem[flash_i.addr] <= flash_i.wdata;
	end
	// ----------------------------------------
	// read data, held for a while then released
	// ----------------------------------------
	always @(posedge clk_i)
	begin
		if (flash_i.rd)
		begin
			val_q <= mem[flash_i.addr];
			hold_q <= 5'h10;
		end
		else if (hold_q != 5'h00)
			hold_q <= hold_q - 5'h01;
	end
	// released lines show the inverse of the last word
	assign rdata_o = (hold_q != 5'h00) ? val_q : ~val_q;
endmodule // fips_flash_model

// ===== tb/fips_top_test.sv
// self-checking bench of the flash iap program sequencer
`timescale 1ns/1ns
module fips_top_test;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	fips_pkg::fips_bus_t bus_i = '0;
	logic [7:0] rdata_o;
	fips_pkg::fips_flash_t flash_o;
	logic [15:0] flash_rdata;
	logic cpu_stall_o;
	int err_total = 0;
	int check_count = 0;
	int cycles = 0;
	int n;
	fips_top #(.PROG_CYC_SHORT(20), .PROG_CYC_LONG(40), .UNLOCK_CYC(50)) u_dut (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.bus_i(bus_i),
		.rdata_o(rdata_o),
		.flash_o(flash_o),
		.flash_rdata_i(flash_rdata),
		.cpu_stall_o(cpu_stall_o)
	);
	fips_flash_model u_flash (.clk_i(clk_i), .flash_i(flash_o), .rdata_o(flash_rdata));
	initial forever #4 clk_i = ~clk_i;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check_eq(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge clk_i);
		bus_i <= '{we: 1'b1, re: 1'b0, addr: a, wdata: v};
		@(posedge clk_i);
		bus_i.we <= 1'b0;
	endtask
	task automatic rd_eq(input logic [4:0] a, input logic [7:0] exp, input string what);
		@(posedge clk_i);
		bus_i <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_i);
		bus_i.re <= 1'b0;
		#1;
		check_eq({8'h00, rdata_o}, {8'h00, exp}, what);
	endtask
	task automatic wait_idle(output int cnt);
		cnt = 0;
		#1;
		while (cpu_stall_o !== 1'b0 && cnt < 500)
		begin
			cnt++;
			@(posedge clk_i);
			#1;
		end
		if (cnt == 500)
			check_eq(16'h0001, 16'h0000, "stall timeout");
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			close_out();
		end
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic test_locked();
		rd_eq(5'h00, 8'h00, "ctrl0 reset");
		rd_eq(5'h1f, 8'h00, "unmapped read");
		wr(5'h00, 8'h01);
		wr(5'h01, 8'h01);
		wait_idle(n);
		check_eq(16'(n), 16'h0000, "locked erase stalled");
		$display("test locked done");
	endtask
	task automatic test_read();
		u_flash.mem[13'h0123] = 16'hbeef;
		wr(5'h00, 8'h23);
		wr(5'h03, 8'h23);
		wr(5'h04, 8'h01);
		wr(5'h01, 8'h02);
		rd_eq(5'h01, 8'h02, "read start busy");
		wait_idle(n);
		check_eq(16'(n + 2 >= 12 && n + 2 <= 13), 16'h0001, "read stall length");
		rd_eq(5'h01, 8'h00, "read start cleared");
		rd_eq(5'h05, 8'hef, "read data low");
		rd_eq(5'h06, 8'hbe, "read data high");
		$display("test read done");
	endtask
	task automatic test_unlock();
		wr(5'h00, 8'h0e);
		for (int i = 0; i < 6; i++)
			wr(5'(7 + i), fips_pkg::UNLOCK_KEY[8*i +: 8]);
		rd_eq(5'h00, 8'h1e, "unlocked");
		repeat (60) @(posedge clk_i);
		rd_eq(5'h00, 8'h16, "unlock timer expiry");
		$display("test unlock done");
	endtask
	task automatic test_erase();
		u_flash.mem[13'h00a0] = 16'hffff;
		u_flash.mem[13'h00bf] = 16'hffff;
		wr(5'h03, 8'ha5);
		wr(5'h04, 8'h00);
		wr(5'h00, 8'h11);
		for (int i = 0; i < 32; i++)
			wr(5'h06, 8'h00);
		wr(5'h01, 8'h01);
		wait_idle(n);
		check_eq(16'(n >= 20 && n <= 22), 16'h0001, "short erase time");
		rd_eq(5'h01, 8'h00, "start bit cleared");
		check_eq(u_flash.mem[13'h00a0], 16'h0000, "page start erased");
		check_eq(u_flash.mem[13'h00bf], 16'h0000, "page end erased");
		wr(5'h02, 8'h01);
		wr(5'h01, 8'h01);
		rd_eq(5'h01, 8'h01, "start bit busy");
		wait_idle(n);
		check_eq(16'(n + 2 >= 40 && n + 2 <= 42), 16'h0001, "long erase time");
		$display("test erase done");
	endtask
	task automatic test_write();
		u_flash.mem[13'h00a1] = 16'hffff;
		wr(5'h02, 8'h00);
		wr(5'h00, 8'h10);
		wr(5'h03, 8'hbe);
		wr(5'h04, 8'h00);
		for (int i = 1; i < 4; i++)
		begin
			wr(5'h05, 8'(17 * i));
			wr(5'h06, 8'(17 * i));
		end
		wr(5'h01, 8'h01);
		wait_idle(n);
		check_eq(16'(n >= 52 && n <= 56), 16'h0001, "write time");
		check_eq(u_flash.mem[13'h00be], 16'h1111, "first word");
		check_eq(u_flash.mem[13'h00bf], 16'h3333, "saturated word");
		check_eq(u_flash.mem[13'h00a1], 16'h0000, "unloaded word");
		$display("test write done");
	endtask
	task automatic test_retry();
		wr(5'h01, 8'h04);
		wr(5'h03, 8'ha0);
		wr(5'h05, 8'h44);
		wr(5'h06, 8'h44);
		wr(5'h01, 8'h01);
		wait_idle(n);
		check_eq(u_flash.mem[13'h00a0], 16'h4444, "rewrite same page");
		check_eq(u_flash.mem[13'h00bf], 16'h0000, "buffer cleared");
		wr(5'h00, 8'h00);
		rd_eq(5'h00, 8'h00, "flag cleared");
		wr(5'h01, 8'h01);
		wait_idle(n);
		check_eq(16'(n), 16'h0000, "relocked write");
		$display("test retry done");
	endtask
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		test_locked();
		test_read();
		test_unlock();
		test_erase();
		test_write();
		test_retry();
		close_out();
	end
endmodule // fips_top_test
